// ===== rtl/rmiw_pkg.sv
package rmiw_pkg;

    // ==========================================================
    // Register map, byte addresses
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] ADDR_CMD  = 8'h00;
    localparam logic [7:0] ADDR_CFG  = 8'h04;
    localparam logic [7:0] ADDR_STS  = 8'h08;
    localparam logic [7:0] ADDR_MSK  = 8'h0c;
    localparam logic [7:0] ADDR_PST  = 8'h10;

    // ==========================================================
    // Command word fields
    localparam int          CMD_CODE_HI   = 15;
    localparam int          CMD_START_BIT = 16;
    localparam int          CMD_IDLE_BIT  = 17;
    localparam logic [15:0] TMO_SINGLE    = 16'h0000;
    localparam logic [15:0] TMO_CONT      = 16'hffff;

    // ==========================================================
    // Configuration word fields
    localparam int         CFG_MODEM_LO = 0;
    localparam int         CFG_MODEM_HI = 1;
    localparam int         CFG_HDR_EN   = 2;
    localparam int         CFG_SYNC_EN  = 3;
    localparam int         CFG_CRC_EN   = 4;
    localparam int         CFG_IQ_INV   = 5;
    localparam int         CFG_SF_LO    = 6;
    localparam int         CFG_SF_HI    = 9;
    localparam int         CFG_BW_LO    = 10;
    localparam int         CFG_BW_HI    = 11;
    localparam int         CFG_CR_LO    = 12;
    localparam int         CFG_CR_HI    = 14;
    localparam int         CFG_LEN_LO   = 15;
    localparam int         CFG_LEN_HI   = 22;
    localparam logic [1:0] MODEM_FSK    = 2'h0;
    localparam logic [1:0] MODEM_LR     = 2'h1;
    localparam logic [1:0] MODEM_FAST   = 2'h2;
    localparam logic [1:0] MODEM_LE     = 2'h3;
    localparam logic [3:0] SF_9         = 4'h9;
    localparam logic [3:0] SF_10        = 4'ha;
    localparam logic [1:0] BW_800       = 2'h2;
    localparam logic [1:0] BW_1600      = 2'h3;
    localparam logic [2:0] CR_4_5       = 3'h1;
    localparam logic [7:0] LEN_ONE      = 8'h01;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;

    // ==========================================================
    // Interrupt bits and packet status fields
    localparam int IRQ_W       = 4;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_EXPIRY  = 1;
    localparam int IRQ_HDR     = 2;
    localparam int IRQ_LOCK    = 3;
    localparam int PST_CRC     = 0;
    localparam int PST_BLOCKED = 1;
    localparam int PST_ST_LO   = 2;
    localparam int PST_ST_HI   = 3;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          TMO_STEP_NS     = 1000;
    localparam int          TMO_STEP_CYC    = (TMO_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RATE_WINDOW_NS  = 1000000000;
    localparam int          RATE_WINDOW_CYC = RATE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int          RATE_CNT_W      = 25;
    localparam logic [8:0]  RATE_LIMIT      = 9'h0dc;

    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_LOCKED} rmiw_state_type;

    // Modem selection test
    function automatic logic rmiw_modem_is(input logic [31:0] cfg, input logic [1:0] m);
        return cfg[CFG_MODEM_HI:CFG_MODEM_LO] == m;
    endfunction

endpackage

// ===== rtl/rmiw_irq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rmiw_irq_if
    import rmiw_pkg::*;
();
    logic [IRQ_W-1:0] set;
    logic [IRQ_W-1:0] clr;
    logic             mask_we;
    logic [IRQ_W-1:0] mask_wdata;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic             line;

    modport ctl (output set, clr, mask_we, mask_wdata, input status, mask, line);
    modport blk (input set, clr, mask_we, mask_wdata, output status, mask, line);
endinterface
`default_nettype wire

// ===== rtl/rmiw_irq.sv
`timescale 1ns/1ps
`default_nettype none
module rmiw_irq
    import rmiw_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    rmiw_irq_if.blk   bus
);
    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] status_d;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] mask_d;
    logic             line_q;

    // ==========================================================
    // Sticky status, set wins over clear
    assign status_d   = (status_q & ~bus.clr) | bus.set;
    assign mask_d     = bus.mask_we ? bus.mask_wdata : mask_q;
    assign bus.status = status_q;
    assign bus.mask   = mask_q;
    assign bus.line   = line_q;

    // Status, mask and line flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
            mask_q   <= '0;
            line_q   <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            line_q   <= |(status_d & mask_d);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    chk_set_wins: assert property ((bus.set[IRQ_DONE] && bus.clr[IRQ_DONE])
        |=> status_q[IRQ_DONE]) else $error("event lost against clear");
    chk_line_mask: assert property (##1 line_q == |(status_q & mask_q))
        else $error("irq line disagrees with masked status");
endmodule
`default_nettype wire

// ===== rtl/rmiw_rate.sv
`timescale 1ns/1ps
`default_nettype none
module rmiw_rate
    import rmiw_pkg::*;
#(
    parameter int WINDOW_CYC = RATE_WINDOW_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic pkt,
    output logic      overload
);
    logic [RATE_CNT_W-1:0] win_q;
    logic [8:0]            cnt_q;
    logic                  over_q;
    logic                  win_end;
    logic                  cnt_sat;

    // ==========================================================
    // Window end and saturation decode
    assign win_end  = win_q == RATE_CNT_W'(WINDOW_CYC - 1);
    assign cnt_sat  = &cnt_q;
    assign overload = over_q;

    // Packets counted per window, overload on the one past the limit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_q  <= '0;
            cnt_q  <= '0;
            over_q <= 1'b0;
        end else begin
            win_q  <= (!enable || win_end) ? '0 : win_q + 1'b1;
            cnt_q  <= (!enable || win_end) ? '0 : cnt_q + 9'(pkt && !cnt_sat);
            over_q <= enable && pkt && (cnt_q == RATE_LIMIT);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/rmiw_top.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rmiw_top
    import rmiw_pkg::*;
#(
    parameter int RATE_WINDOW_CYC_P = RATE_WINDOW_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              demod_pkt_done,
    input  wire logic              demod_crc_bad,
    input  wire logic              demod_hdr_fault,
    input  wire logic              demod_preamble_seen,
    output logic                   rx_enable,
    output logic                   busy,
    output logic                   irq_output_line
);
    rmiw_irq_if irq_bus ();

    rmiw_state_type state_q;
    rmiw_state_type state_d;
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic [31:0]    cfg_q;
    logic [15:0]    tmo_code_q;
    logic [31:0]    tmo_cnt_q;
    logic [31:0]    tmo_cnt_d;
    logic           blocked_q;
    logic           blocked_d;
    logic           abort_q;
    logic           abort_d;
    logic           crc_fail_q;
    logic           busy_q;
    logic           rx_en_q;

    logic           apb_req;
    logic           acc;
    logic           wr_acc;
    logic           sel_cmd;
    logic           sel_cfg;
    logic           sel_sts;
    logic           sel_msk;
    logic           sel_pst;
    logic           sel_ok;
    logic [31:0]    rdata_mux;
    logic           cmd_wr;
    logic           start;
    logic           go_idle;
    logic           in_rx;
    logic           cont;
    logic           single;
    logic           timed;
    logic           quirk;
    logic           take_pkt;
    logic           sync_hit;
    logic           hdr_hit;
    logic           expired;
    logic           overload;
    logic           lock_evt;
    logic [31:0]    tmo_load;
    logic [31:0]    pst_word;

    // ==========================================================
    // APB decode
    assign apb_req = psel && penable && !pready_q;
    assign acc     = psel && penable && pready_q;
    assign wr_acc  = acc && pwrite;
    assign sel_cmd = paddr == ADDR_CMD;
    assign sel_cfg = paddr == ADDR_CFG;
    assign sel_sts = paddr == ADDR_STS;
    assign sel_msk = paddr == ADDR_MSK;
    assign sel_pst = paddr == ADDR_PST;
    assign sel_ok  = sel_cmd || sel_cfg || sel_sts || sel_msk || sel_pst;

    // Packet status word
    assign pst_word = {28'h0000000, 2'(state_q), blocked_q, crc_fail_q};

    // Read data selection
    assign rdata_mux = sel_cmd ? {16'h0000, tmo_code_q} :
                       sel_cfg ? cfg_q :
                       sel_sts ? {28'h0000000, irq_bus.status} :
                       sel_msk ? {28'h0000000, irq_bus.mask} :
                       sel_pst ? pst_word : 32'h0000_0000;

    // ==========================================================
    // Command decode, ignored while locked up
    assign cmd_wr   = wr_acc && sel_cmd && (state_q != ST_LOCKED);
    assign start    = cmd_wr && pwdata[CMD_START_BIT];
    assign go_idle  = cmd_wr && pwdata[CMD_IDLE_BIT] && !pwdata[CMD_START_BIT];
    assign tmo_load = 32'(pwdata[CMD_CODE_HI:0]) * 32'(TMO_STEP_CYC) - 32'h0000_0001;

    // Receive mode decode
    assign in_rx  = state_q == ST_RX;
    assign cont   = tmo_code_q == TMO_CONT;
    assign single = tmo_code_q == TMO_SINGLE;
    assign timed  = !cont && !single;

    assign quirk = rmiw_modem_is(cfg_q, MODEM_LR)
                && cfg_q[CFG_LEN_HI:CFG_LEN_LO] == LEN_ONE
                && (cfg_q[CFG_SF_HI:CFG_SF_LO] == SF_9 || cfg_q[CFG_SF_HI:CFG_SF_LO] == SF_10)
                && (cfg_q[CFG_BW_HI:CFG_BW_LO] == BW_800
                    || cfg_q[CFG_BW_HI:CFG_BW_LO] == BW_1600)
                && cfg_q[CFG_CR_HI:CFG_CR_LO] == CR_4_5
                && cfg_q[CFG_HDR_EN] && !cfg_q[CFG_CRC_EN] && !cfg_q[CFG_IQ_INV];

    assign take_pkt = in_rx && demod_pkt_done && !blocked_q && !quirk && !abort_q;

    assign sync_hit = in_rx && rmiw_modem_is(cfg_q, MODEM_FAST) && cfg_q[CFG_SYNC_EN]
                   && demod_preamble_seen;

    // header fault in long-range with header
    assign hdr_hit = in_rx && rmiw_modem_is(cfg_q, MODEM_LR) && cfg_q[CFG_HDR_EN]
                  && demod_hdr_fault;

    // Expiry of a timed receive
    assign expired = in_rx && timed && !blocked_q && !quirk && !take_pkt
                  && tmo_cnt_q == 32'h0000_0000;

    assign lock_evt = in_rx && cont && overload;

    // ==========================================================
    // Receive mode state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_RX;
                end
            end
            ST_RX: begin
                if (lock_evt) begin
                    state_d = ST_LOCKED;
                end else if (start) begin
                    state_d = ST_RX;
                end else if (go_idle) begin
                    state_d = ST_IDLE;
                end else if (take_pkt && !cont) begin
                    state_d = ST_IDLE;
                end else if (expired) begin
                    state_d = ST_IDLE;
                end
            end
            ST_LOCKED: begin
                state_d = ST_LOCKED;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Block and abort flags, timeout counter
    assign blocked_d = hdr_hit || (blocked_q && !(start || go_idle)); // Fault wins over rearm
    assign abort_d   = (start || demod_pkt_done) ? 1'b0 : (abort_q || sync_hit);
    assign tmo_cnt_d = start ? tmo_load :
                       (in_rx && tmo_cnt_q != 32'h0000_0000) ? tmo_cnt_q - 32'h0000_0001 :
                       tmo_cnt_q;

    // ==========================================================
    // Interrupt events and software access
    // completion flagged per packet, except blocked, sync-spoiled or silent-setting ones
    assign irq_bus.set        = {lock_evt, hdr_hit, expired, take_pkt};
    assign irq_bus.clr        = (wr_acc && sel_sts) ? pwdata[IRQ_W-1:0] : '0;
    assign irq_bus.mask_we    = wr_acc && sel_msk;
    assign irq_bus.mask_wdata = pwdata[IRQ_W-1:0];

    rmiw_irq u_irq (
        .clk (clk),
        .rst (rst),
        .bus (irq_bus)
    );

    rmiw_rate #(
        .WINDOW_CYC (RATE_WINDOW_CYC_P)
    ) u_rate (
        .clk      (clk),
        .rst      (rst),
        .enable   (in_rx && cont),
        .pkt      (demod_pkt_done),
        .overload (overload)
    );

    // APB answer flops, one wait state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= apb_req;
            prdata_q  <= (apb_req && !pwrite) ? rdata_mux : prdata_q;
            pslverr_q <= apb_req && !sel_ok;
        end
    end

    // Configuration and command registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q      <= CFG_RESET;
            tmo_code_q <= TMO_SINGLE;
        end else begin
            cfg_q      <= (wr_acc && sel_cfg) ? pwdata : cfg_q;
            tmo_code_q <= start ? pwdata[CMD_CODE_HI:0] : tmo_code_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            tmo_cnt_q  <= '0;
            blocked_q  <= 1'b0;
            abort_q    <= 1'b0;
            crc_fail_q <= 1'b0;
            busy_q     <= 1'b0;
            rx_en_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            tmo_cnt_q  <= tmo_cnt_d;
            blocked_q  <= blocked_d;
            abort_q    <= abort_d;
            crc_fail_q <= take_pkt ? demod_crc_bad : crc_fail_q;
            busy_q     <= (state_d == ST_LOCKED) || cmd_wr;
            rx_en_q    <= state_d == ST_RX;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign rx_enable       = rx_en_q;
    assign busy            = busy_q;
    assign irq_output_line = irq_bus.line;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_cont_stays: assert property ((in_rx && cont && !cmd_wr && !lock_evt)
        |=> state_q == ST_RX) else $error("continuous receive left");
    chk_done_sets: assert property (take_pkt |=> irq_bus.status[IRQ_DONE])
        else $error("completion flag missing");
    chk_single_idle: assert property ((take_pkt && single && !start && !lock_evt)
        |=> state_q == ST_IDLE && !rx_en_q) else $error("single did not end");
    chk_lock_hold: assert property (lock_evt |=> (busy_q && state_q == ST_LOCKED)[*8])
        else $error("lock-up not held");
    chk_hdr_block: assert property ((blocked_q && !start)
        |-> !irq_bus.set[IRQ_DONE] && !irq_bus.set[IRQ_EXPIRY])
        else $error("blocked receive completed");
    chk_crc_nofilt: assert property ((take_pkt && demod_crc_bad)
        |=> irq_bus.status[IRQ_DONE] && crc_fail_q) else $error("bad packet filtered");
    chk_sync_spoil: assert property ((abort_q && demod_pkt_done)
        |-> !irq_bus.set[IRQ_DONE]) else $error("spoiled packet completed");
    chk_nosync_keep: assert property ((in_rx && rmiw_modem_is(cfg_q, MODEM_FAST)
        && !cfg_q[CFG_SYNC_EN] && demod_pkt_done && !blocked_q && !abort_q)
        |-> take_pkt) else $error("packet lost without sync");
    chk_quirk_quiet: assert property (quirk
        |-> !irq_bus.set[IRQ_DONE] && !irq_bus.set[IRQ_EXPIRY])
        else $error("silent setting raised irq");
endmodule
`default_nettype wire

// ===== tb/rmiw_host.sv
`timescale 1ns/1ps
`default_nettype none
module rmiw_host
    import rmiw_pkg::*;
(
    input  wire logic              clk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [31:0]       pwdata,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    logic err_q;

    // ==========================================================
    // Bus cycles
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        err_q = 1'b0;
    end

    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Answer taken at the edge where pready is sampled high
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            receive_mode_irq_workarounds_bench.n_errors++;
            receive_mode_irq_workarounds_bench.summarize();
        end else begin
            q       = prdata;
            err_q   = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic listen(input logic [15:0] code);
        wr(ADDR_CMD, {14'h0, 2'b01, code});
    endtask

    function automatic logic sync_legal(input logic [31:0] w, input logic cr34);
        return w[31:16] != 16'h8c38 && w[31:16] != 16'h630e
            && !(cr34 && w[15:0] <= 16'h3eff);
    endfunction
endmodule
`default_nettype wire

// ===== tb/receive_mode_irq_workarounds_bench.sv
`timescale 1ns/1ps
`default_nettype none
module receive_mode_irq_workarounds_bench;
    import rmiw_pkg::*;
    localparam int WIN = 2000;
    logic              clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, sw;
    logic              pkt, bad, hdr, pre, rx_enable, busy, irq_output_line, b;
    int                n_errors, checks, seed, i, s;

    // ==========================================================
    // Design and host
    rmiw_top #(.RATE_WINDOW_CYC_P(WIN)) dut_u (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .demod_pkt_done(pkt),
        .demod_crc_bad(bad), .demod_hdr_fault(hdr), .demod_preamble_seen(pre),
        .rx_enable, .busy, .irq_output_line);
    rmiw_host host_u (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    always #25 clk = ~clk;

    // Configuration word from fields
    function automatic logic [31:0] mk_cfg(logic [1:0] m, logic h, logic y, logic [3:0] sf,
                                           logic [1:0] bw, logic [2:0] cr, logic [7:0] len);
        return {9'h0, len, cr, bw, sf, 2'b00, y, h, m};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host_u.rd(a, q);
        chk(q, exp);
    endtask

    // Demodulator event, then let effects land
    task automatic ev(input logic d, input logic e, input logic h, input logic p);
        @(posedge clk);
        pkt <= d;
        bad <= e;
        hdr <= h;
        pre <= p;
        @(posedge clk);
        pkt <= 1'b0;
        hdr <= 1'b0;
        pre <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic start(input logic [15:0] code);
        host_u.listen(code);
        @(negedge clk);
        chk(busy, 1'b1);
        chk(rx_enable, 1'b1);
        @(negedge clk);
        chk(busy, 1'b0);
    endtask

    task automatic summarize;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'hc3c6;
        clk = 1'b0;
        rst = 1'b1;
        {pkt, bad, hdr, pre} = 4'h0;
        n_errors = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdchk(ADDR_CFG, 32'h0);
        rdchk(ADDR_STS, 32'h0);
        rdchk(ADDR_MSK, 32'h0);
        rdchk(ADDR_PST, 32'h0);
        rdchk(8'h20, 32'h0);
        chk(host_u.err_q, 1'b1);
        host_u.wr(ADDR_MSK, 32'hf);
        rdchk(ADDR_MSK, 32'hf);
        $display("test reset done");
        // Single receive, random checksum result
        host_u.wr(ADDR_CFG, mk_cfg(MODEM_FSK, 0, 0, 4'h0, 2'h0, 3'h0, 8'h0));
        for (i = 0; i < 4; i++) begin
            b = 1'($random(seed));
            start(TMO_SINGLE);
            ev(1'b1, b, 1'b0, 1'b0);
            chk(rx_enable, 1'b0);
            chk(irq_output_line, 1'b1);
            rdchk(ADDR_STS, 32'h1);
            rdchk(ADDR_PST, {31'h0, b});
            host_u.wr(ADDR_STS, 32'h1);
            repeat (2) @(negedge clk);
            chk(irq_output_line, 1'b0);
        end
        $display("test single done");
        // Continuous receive, masking
        start(TMO_CONT);
        s = 3 + ($random(seed) & 3);
        for (i = 0; i < s; i++) begin
            ev(1'b1, 1'b0, 1'b0, 1'b0);
            chk(rx_enable, 1'b1);
            rdchk(ADDR_STS, 32'h1);
            host_u.wr(ADDR_STS, 32'h1);
        end
        host_u.wr(ADDR_MSK, 32'h0);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        chk(irq_output_line, 1'b0);
        host_u.wr(ADDR_MSK, 32'hf);
        repeat (2) @(negedge clk);
        chk(irq_output_line, 1'b1);
        host_u.wr(ADDR_STS, 32'hf);
        host_u.wr(ADDR_CMD, 32'h0002_0000);
        repeat (2) @(negedge clk);
        chk(rx_enable, 1'b0);
        $display("test continuous done");
        // Header fault blocks completion until rearm
        host_u.wr(ADDR_CFG, mk_cfg(MODEM_LR, 1, 0, SF_9, 2'h0, 3'h0, 8'h0));
        start(TMO_SINGLE);
        ev(1'b0, 1'b0, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        rdchk(ADDR_STS, 32'h4);
        rdchk(ADDR_PST, 32'h6);
        host_u.wr(ADDR_STS, 32'h4);
        start(TMO_SINGLE);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        rdchk(ADDR_STS, 32'h1);
        host_u.wr(ADDR_STS, 32'h1);
        $display("test header done");
        // Fast modem with and without sync search
        chk(host_u.sync_legal(32'h8c38_ffff, 1'b0), 1'b0);
        chk(host_u.sync_legal(32'h1234_3eff, 1'b1), 1'b0);
        for (s = 0; s < 2; s++) begin
            sw = $random(seed);
            if (!host_u.sync_legal(sw, s[0])) sw = {2'b00, sw[29:16], 2'b11, sw[13:0]};
            chk(host_u.sync_legal(sw, s[0]), 1'b1);
            host_u.wr(ADDR_CFG, mk_cfg(MODEM_FAST, 0, s[0], 4'h0, 2'h0, 3'h0, 8'h0));
            start(TMO_SINGLE);
            ev(1'b0, 1'b0, 1'b0, 1'b1);
            ev(1'b1, 1'b0, 1'b0, 1'b0);
            rdchk(ADDR_STS, {31'h0, ~s[0]});
            host_u.wr(ADDR_STS, 32'h1);
            host_u.wr(ADDR_CMD, 32'h0002_0000);
        end
        $display("test sync done");
        // Timed expiry, and the silent long-range setting
        for (s = 0; s < 2; s++) begin
            host_u.wr(ADDR_CFG, s ? mk_cfg(MODEM_LR, 1, 0, ($random(seed) & 1) ? SF_10 : SF_9,
                      ($random(seed) & 1) ? BW_1600 : BW_800, CR_4_5, LEN_ONE) : 32'h0);
            start(16'h0002);
            if (s) ev(1'b1, 1'b0, 1'b0, 1'b0);
            repeat (30) @(negedge clk);
            chk(irq_output_line, 1'b0);
            repeat (20) @(negedge clk);
            rdchk(ADDR_STS, s ? 32'h0 : 32'h2);
            host_u.wr(ADDR_STS, 32'hf);
            host_u.wr(ADDR_CMD, 32'h0002_0000);
        end
        $display("test timed done");
        // Congested continuous receive, after a second reset
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(ADDR_MSK, 32'h0);
        host_u.wr(ADDR_CFG, mk_cfg(MODEM_LE, 0, 0, 4'h0, 2'h0, 3'h0, 8'h0));
        start(TMO_CONT);
        for (i = 0; i < 220; i++) ev(1'b1, 1'b0, 1'b0, 1'b0);
        chk(busy, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        chk(busy, 1'b1);
        chk(rx_enable, 1'b0);
        rdchk(ADDR_PST, 32'h8);
        rdchk(ADDR_STS, 32'h9);
        host_u.wr(ADDR_CMD, 32'h0001_0000);
        repeat (2) @(negedge clk);
        chk(busy, 1'b1);
        chk(rx_enable, 1'b0);
        $display("test lockup done");
        summarize();
    end
endmodule
`default_nettype wire
